// file: cpf_cfg.svh
// Offsets, field positions, reset values and fixed feature values
// for the port's feature identification register bank.
// Assumes a 32-bit APB bus with byte addresses.
`ifndef CPF_CFG_SVH
`define CPF_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CPF_TX_FEAT_OFS 12'h008
`define CPF_RX_FEAT_OFS 12'h00c
`define CPF_STATUS_OFS 12'h010
`define CPF_DATA_NB_OFS 12'h020
`define CPF_INT_STAT_OFS 12'h024
`define CPF_INT_CLR_OFS 12'h028
`define CPF_INT_EN_OFS 12'h02c

// ****************************************************************
// Receive feature fields
// ****************************************************************
`define CPF_RXF_DEPTH_HI 19
`define CPF_RXF_DEPTH_LO 16
`define CPF_RXF_SZ32_BIT 10
`define CPF_RXF_SZ16_BIT 9
`define CPF_RXF_SZ8_BIT 8
`define CPF_RXF_INT_BIT 1
`define CPF_RXF_PRES_BIT 0

// ****************************************************************
// Fixed feature values of this build
// ****************************************************************
`define CPF_DEPTH_CODE 4'h4
`define CPF_FIFO_BYTES 5'h10
`define CPF_HAS_RX 1'b1
`define CPF_HAS_RX_INT 1'b1
`define CPF_HAS_SZ32 1'b1
`define CPF_HAS_SZ16 1'b0
`define CPF_HAS_SZ8 1'b0
`define CPF_TX_FEAT_VAL 32'h0000_0000
`define CPF_NULL_BYTE 8'h00

// ****************************************************************
// Status and interrupt fields, reset values
// ****************************************************************
`define CPF_ST_FULL_BIT 0
`define CPF_ST_LOST_BIT 1
`define CPF_ST_FILL_LO 4
`define CPF_INT_RECV_BIT 0
`define CPF_INT_LOST_BIT 1
`define CPF_INT_RST 2'h0
`define CPF_BYTES_PER_WORD 2'h3
`define CPF_DATA_RD_MAX 10

`endif

// file: cpf_pkg.sv
// Types shared by the feature register bank and its receive store.
// Assumes cpf_cfg.svh holds the numeric constants.
package cpf_pkg;

    // Data port read sequencer, Gray coded along the read path except the ADDR to DONE step
    typedef enum logic [1:0] {
        CPF_RD_IDLE = 2'b00,
        CPF_RD_ADDR = 2'b01,
        CPF_RD_TAKE = 2'b11,
        CPF_RD_DONE = 2'b10
    } cpf_rd_state_t;

    // Receive store state seen by software
    typedef struct packed {
        logic [4:0] fill;  // Bytes held
        logic lost;        // Byte dropped while full
        logic full;        // Store full
    } cpf_rx_stat_t;

endpackage

// file: cpf_rx_mem.sv
// Receive byte store: 16 bytes, one write port, registered read.
// Assumes the owner keeps the read and write pointers.
`timescale 1ns/1ns
module cpf_rx_mem (
    input wire logic i_clk,          // System clock
    input wire logic i_we,           // Write strobe
    input wire logic [3:0] i_waddr,  // Write address
    input wire logic [7:0] i_wdata,  // Write byte
    input wire logic [3:0] i_raddr,  // Read address
    output logic [7:0] o_rdata       // Read byte, one cycle late
);
    logic [7:0] mem [16];  // Byte storage

    // Write and registered read
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

// file: cpf_feature_regs.sv
// Feature identification bank of a communications port, with the
// non-blocking data port read side, status and interrupt registers.
// Assumes an APB master on I_SYS_CLK and a receive byte source on
// the same clock.
`timescale 1ns/1ns
`include "cpf_cfg.svh"
module cpf_feature_regs
    import cpf_pkg::*;
(
    input wire logic I_SYS_CLK,            // 50 MHz clock
    input wire logic I_SYS_RST,            // Sync reset, high
    input wire logic I_PSEL,               // APB select
    input wire logic I_PENABLE,            // APB access phase
    input wire logic I_PWRITE,             // APB write
    input wire logic [11:0] I_PADDR,       // APB byte address
    input wire logic [31:0] I_PWDATA,      // APB write data
    input wire logic I_RX_VALID,           // Received byte strobe
    input wire logic [7:0] I_RX_DATA,      // Received byte
    output logic [31:0] O_PRDATA,          // APB read data
    output logic O_PREADY,                 // APB ready
    output logic O_PSLVERR,                // APB error
    output logic O_IRQ                     // Interrupt, level
);

    // ************************************************************
    // Helpers
    // ************************************************************

    // Builds the receive feature word; absent path zeroes fields
    function automatic logic [31:0] rx_feature(input logic has_rx);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (has_rx) begin
            w[`CPF_RXF_DEPTH_HI:`CPF_RXF_DEPTH_LO] = `CPF_DEPTH_CODE;
            w[`CPF_RXF_SZ32_BIT] = `CPF_HAS_SZ32;
            w[`CPF_RXF_SZ16_BIT] = `CPF_HAS_SZ16;
            w[`CPF_RXF_SZ8_BIT] = `CPF_HAS_SZ8;
            w[`CPF_RXF_INT_BIT] = `CPF_HAS_RX_INT;
            w[`CPF_RXF_PRES_BIT] = 1'b1;
        end
        return w;  // Reserved bits stay zero
    endfunction

    // Matches an address against a register offset
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] ofs);
        return a == ofs;
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************
    logic setup;                      // APB setup cycle
    logic done;                       // APB transfer completes
    logic data_rd;                    // Setup of a data port read
    logic [4:0] wr_ptr_reg;           // Store write pointer
    logic [4:0] rd_ptr_reg;           // Store read pointer
    cpf_rx_stat_t rx_stat;            // Store state
    logic push;                       // Byte accepted
    logic drop;                       // Byte lost, store full
    logic pop;                        // Byte taken by a read
    logic [7:0] mem_rdata;            // Byte at read pointer
    cpf_rd_state_t rd_state_reg;      // Data read sequencer
    logic [1:0] lane_reg;             // Lane being filled
    logic [2:0] taken_reg;            // Bytes taken this read
    logic [31:0] asm_reg;             // Word being assembled
    logic lost_reg;                   // Lost data flag
    logic [1:0] int_stat_reg;         // Sticky interrupt status
    logic [1:0] int_en_reg;           // Interrupt enables
    logic [1:0] int_clr;              // Clear strobes
    logic [31:0] rd_word;             // Read mux result
    logic rd_ok;                      // Address mapped

    assign setup = I_PSEL && !I_PENABLE;
    assign done = I_PSEL && I_PENABLE && O_PREADY;
    assign data_rd = setup && !I_PWRITE
                     && hit(I_PADDR, `CPF_DATA_NB_OFS);

    // ************************************************************
    // Receive store
    // ************************************************************
    assign rx_stat.fill = wr_ptr_reg - rd_ptr_reg;
    assign rx_stat.full = rx_stat.fill == `CPF_FIFO_BYTES;
    assign rx_stat.lost = lost_reg;
    assign push = I_RX_VALID && !rx_stat.full;
    assign drop = I_RX_VALID && rx_stat.full;
    assign pop = rd_state_reg == CPF_RD_TAKE;

    cpf_rx_mem u_mem (
        .i_clk(I_SYS_CLK),
        .i_we(push),
        .i_waddr(wr_ptr_reg[3:0]),
        .i_wdata(I_RX_DATA),
        .i_raddr(rd_ptr_reg[3:0]),
        .o_rdata(mem_rdata)
    );

    // Pointer upkeep
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            wr_ptr_reg <= 5'h00;
            rd_ptr_reg <= 5'h00;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 5'h01;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 5'h01;
            end
        end
    end

    // ************************************************************
    // Data port read sequencer
    // ************************************************************

    // Fills lanes from lowest, oldest byte first
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            rd_state_reg <= CPF_RD_IDLE;
            lane_reg <= 2'h0;
            taken_reg <= 3'h0;
            asm_reg <= 32'h0000_0000;
        end else begin
            case (rd_state_reg)
                CPF_RD_IDLE: begin
                    // Start on a data port read
                    if (data_rd) begin
                        rd_state_reg <= CPF_RD_ADDR;
                        lane_reg <= 2'h0;
                        taken_reg <= 3'h0;
                    end
                end
                CPF_RD_ADDR: begin
                    // Byte waiting: fetch; else pad with null
                    if (rx_stat.fill != 5'h00) begin
                        rd_state_reg <= CPF_RD_TAKE;
                    end else begin
                        asm_reg[lane_reg*8 +: 8] <= `CPF_NULL_BYTE;
                        lane_reg <= lane_reg + 2'h1;
                        if (lane_reg == `CPF_BYTES_PER_WORD) begin
                            rd_state_reg <= CPF_RD_DONE;
                        end
                    end
                end
                CPF_RD_TAKE: begin
                    // Oldest byte lands in the lowest free lane
                    asm_reg[lane_reg*8 +: 8] <= mem_rdata;
                    lane_reg <= lane_reg + 2'h1;
                    taken_reg <= taken_reg + 3'h1;
                    if (lane_reg == `CPF_BYTES_PER_WORD) begin
                        rd_state_reg <= CPF_RD_DONE;
                    end else begin
                        rd_state_reg <= CPF_RD_ADDR;
                    end
                end
                CPF_RD_DONE: begin
                    rd_state_reg <= CPF_RD_IDLE;
                end
                default: begin
                    rd_state_reg <= CPF_RD_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Register read mux
    // ************************************************************
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        if (hit(I_PADDR, `CPF_RX_FEAT_OFS)) begin
            rd_word = rx_feature(`CPF_HAS_RX);
        end else if (hit(I_PADDR, `CPF_TX_FEAT_OFS)) begin
            rd_word = `CPF_TX_FEAT_VAL;
        end else if (hit(I_PADDR, `CPF_STATUS_OFS)) begin
            rd_word[`CPF_ST_FULL_BIT] = rx_stat.full;
            rd_word[`CPF_ST_LOST_BIT] = rx_stat.lost;
            rd_word[`CPF_ST_FILL_LO +: 5] = rx_stat.fill;
        end else if (hit(I_PADDR, `CPF_INT_STAT_OFS)) begin
            rd_word[1:0] = int_stat_reg;
        end else if (hit(I_PADDR, `CPF_INT_EN_OFS)) begin
            rd_word[1:0] = int_en_reg;
        end else if (hit(I_PADDR, `CPF_INT_CLR_OFS)) begin
            rd_word = 32'h0000_0000;  // Write-only, reads zero
        end else begin
            rd_ok = 1'b0;  // Unmapped
        end
    end

    // ************************************************************
    // APB answer
    // ************************************************************

    // Plain registers answer at once; data reads wait for sequencer
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            O_PREADY <= 1'b0;
            O_PRDATA <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end else if (done) begin
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
        end else if (rd_state_reg == CPF_RD_DONE) begin
            O_PREADY <= 1'b1;
            O_PRDATA <= asm_reg;
        end else if (setup && !data_rd) begin
            O_PREADY <= 1'b1;
            O_PRDATA <= I_PWRITE ? 32'h0000_0000 : rd_word;
            // Data port writes are accepted; no transmit path
            O_PSLVERR <= !rd_ok && !hit(I_PADDR, `CPF_DATA_NB_OFS);
        end
    end

    // ************************************************************
    // Status, interrupts
    // ************************************************************
    assign int_clr = (done && I_PWRITE && hit(I_PADDR, `CPF_INT_CLR_OFS))
                     ? I_PWDATA[1:0] : 2'h0;

    // Lost data flag, cleared with its interrupt bit; set wins
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            lost_reg <= 1'b0;
        end else if (drop) begin
            lost_reg <= 1'b1;
        end else if (int_clr[`CPF_INT_LOST_BIT]) begin
            lost_reg <= 1'b0;
        end
    end

    // Sticky status: set beats clear in the same cycle
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            int_stat_reg <= `CPF_INT_RST;
        end else begin
            int_stat_reg <= (int_stat_reg & ~int_clr) | {drop, push};
        end
    end

    // Enable register; feature writes touch nothing
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            int_en_reg <= `CPF_INT_RST;
        end else if (done && I_PWRITE
                     && hit(I_PADDR, `CPF_INT_EN_OFS)) begin
            int_en_reg <= I_PWDATA[1:0];
        end
    end

    // Interrupt output, registered
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            O_IRQ <= 1'b0;
        end else begin
            O_IRQ <= |(int_stat_reg & int_en_reg);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);

    sequence rx_feat_rd_s;
        done && !I_PWRITE && hit(I_PADDR, `CPF_RX_FEAT_OFS);
    endsequence

    sequence data_rd_s;
        data_rd && rd_state_reg == CPF_RD_IDLE;
    endsequence

    rx_feat_val_a: assert property (
        rx_feat_rd_s |-> O_PRDATA == rx_feature(`CPF_HAS_RX)
                         && !O_PSLVERR)
        else $error("receive feature word wrong");
    rx_reserved_a: assert property (
        rx_feat_rd_s |-> O_PRDATA[31:20] == 12'h000
                         && O_PRDATA[15:11] == 5'h00
                         && O_PRDATA[7:2] == 6'h00)
        else $error("reserved feature bits not zero");
    fifo_depth_a: assert property (
        I_RX_VALID && rx_stat.fill == 5'h0f && !pop
        |=> rx_stat.full && rx_stat.fill <= `CPF_FIFO_BYTES)
        else $error("store does not hold its depth");
    absent_zero_a: assert property (
        rx_feature(1'b0) == 32'h0000_0000)
        else $error("absent receive path fields not zero");
    rx_sizes_a: assert property (
        rx_feat_rd_s |-> O_PRDATA[10:8] == 3'b100)
        else $error("access size bits wrong");
    rx_int_bit_a: assert property (
        rx_feat_rd_s |-> O_PRDATA[1])
        else $error("interrupt present bit clear");
    rx_present_a: assert property (
        rx_feat_rd_s |-> O_PRDATA[0] && O_PRDATA[19:16] == 4'h4)
        else $error("receive present or depth wrong");
    tx_feat_val_a: assert property (
        done && !I_PWRITE && hit(I_PADDR, `CPF_TX_FEAT_OFS)
        |-> O_PRDATA == `CPF_TX_FEAT_VAL && !O_PSLVERR)
        else $error("transmit feature word wrong");
    data_answer_a: assert property (
        data_rd_s |=> !O_PREADY ##[1:`CPF_DATA_RD_MAX] O_PREADY)
        else $error("data port read not answered");
    null_pad_a: assert property (
        rd_state_reg == CPF_RD_DONE && taken_reg == 3'h0
        |=> O_PRDATA == {4{`CPF_NULL_BYTE}})
        else $error("empty read not null padded");
    feat_write_a: assert property (
        done && I_PWRITE && (hit(I_PADDR, `CPF_RX_FEAT_OFS)
                             || hit(I_PADDR, `CPF_TX_FEAT_OFS))
        |-> !O_PSLVERR ##1 $stable(int_en_reg))
        else $error("feature write changed state");
    set_wins_a: assert property (
        push && int_clr[0] |=> int_stat_reg[0])
        else $error("event lost against clear");
endmodule

// file: com_port_feature_id_regs_bench.sv
// Self-checking bench for the port's feature identification bank.
// Assumes cpf_feature_regs on one 50 MHz clock, driven over APB,
// with the receive byte strobe driven straight from the bench.
`timescale 1ns/1ns
`include "cpf_cfg.svh"
module com_port_feature_id_regs_bench;

    // ************************************************************
    // Bench signals
    // ************************************************************
    logic sys_clk;              // 50 MHz clock
    logic sys_rst;              // Sync reset, high
    logic psel;                 // APB select
    logic penable;              // APB access phase
    logic pwrite;               // APB direction
    logic [11:0] paddr;         // APB byte address
    logic [31:0] pwdata;        // APB write data
    logic rx_valid;             // Received byte strobe
    logic [7:0] rx_data;        // Received byte
    logic [31:0] prdata;        // APB read data
    logic pready;               // APB ready
    logic pslverr;              // APB error
    logic irq;                  // Interrupt level
    int miscompares;            // Mismatches seen
    int tests_run;              // Comparisons made
    int cycles;                 // Clock cycles since start
    logic [31:0] rd;            // Last read data
    logic err;                  // Last error flag
    logic [7:0] b;              // Expected byte base
    logic [31:0] rx_feat;       // Expected receive feature word

    // ************************************************************
    // Design under test
    // ************************************************************
    cpf_feature_regs i_dut (
        .I_SYS_CLK(sys_clk),
        .I_SYS_RST(sys_rst),
        .I_PSEL(psel),
        .I_PENABLE(penable),
        .I_PWRITE(pwrite),
        .I_PADDR(paddr),
        .I_PWDATA(pwdata),
        .I_RX_VALID(rx_valid),
        .I_RX_DATA(rx_data),
        .O_PRDATA(prdata),
        .O_PREADY(pready),
        .O_PSLVERR(pslverr),
        .O_IRQ(irq)
    );

    // ************************************************************
    // Clock and hang guard
    // ************************************************************
    // 20 ns period
    always #10 sys_clk = ~sys_clk;

    // Whole run needs well under 2000 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            test_done();
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    // Verdict and end of run
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Compare seen against expected, four-state
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] addr,
                       input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        // Ready sampled before this edge's updates land
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Read and compare data and error flag
    task automatic rdc(input string name, input logic [11:0] addr,
                       input logic [31:0] exp, input logic exp_err);
        apb(1'b0, addr, 32'h0000_0000);
        check(name, rd, exp);
        check({name, "_err"}, {31'h0, err}, {31'h0, exp_err});
    endtask

    // Write and expect the given error flag
    task automatic wrc(input logic [11:0] addr, input logic [31:0] wd,
                       input logic exp_err);
        apb(1'b1, addr, wd);
        check("write_err", {31'h0, err}, {31'h0, exp_err});
    endtask

    // Stream n bytes counting up from first, one per cycle
    task automatic rx_push(input logic [7:0] first, input int n);
        for (int i = 0; i < n; i++) begin
            rx_valid <= 1'b1;
            rx_data <= first + 8'(i);
        @(posedge sys_clk);
        end
        rx_valid <= 1'b0;
        @(posedge sys_clk);
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        miscompares = 0;
        tests_run = 0;
        cycles = 0;
        rx_feat = {12'h000, `CPF_DEPTH_CODE, 5'h00, `CPF_HAS_SZ32,
                   `CPF_HAS_SZ16, `CPF_HAS_SZ8, 6'h00,
                   `CPF_HAS_RX_INT, `CPF_HAS_RX};
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        // Feature words and idle state
        rdc("rx_feature", 12'h00c, rx_feat, 1'b0);
        rdc("tx_feature", 12'h008, `CPF_TX_FEAT_VAL, 1'b0);
        rdc("status", 12'h010, 32'h0000_0000, 1'b0);
        // Feature words and data port ignore writes
        wrc(12'h00c, 32'hffff_ffff, 1'b0);
        wrc(12'h008, 32'hffff_ffff, 1'b0);
        wrc(12'h020, 32'h4433_2211, 1'b0);
        rdc("rx_feature", 12'h00c, rx_feat, 1'b0);
        rdc("tx_feature", 12'h008, `CPF_TX_FEAT_VAL, 1'b0);
        rdc("status", 12'h010, 32'h0000_0000, 1'b0);
        rdc("int_status", 12'h024, 32'h0000_0000, 1'b0);
        // Data port: oldest byte lowest, null padding
        rx_push(8'ha0, 5);
        rdc("status", 12'h010, 32'h0000_0050, 1'b0);
        rdc("data", 12'h020, 32'ha3a2_a1a0, 1'b0);
        rdc("data", 12'h020, {{3{`CPF_NULL_BYTE}}, 8'ha4}, 1'b0);
        rdc("data", 12'h020, {4{`CPF_NULL_BYTE}}, 1'b0);
        rdc("int_status", 12'h024, 32'h0000_0001, 1'b0);
        wrc(12'h028, 32'h0000_0003, 1'b0);
        rdc("int_status", 12'h024, 32'h0000_0000, 1'b0);
        // Store holds 2^N bytes, next one is lost
        rx_push(8'h10, 1 << `CPF_DEPTH_CODE);
        rdc("status", 12'h010, 32'h0000_0101, 1'b0);
        rx_push(8'hee, 1);
        rdc("status", 12'h010, 32'h0000_0103, 1'b0);
        rdc("int_status", 12'h024, 32'h0000_0003, 1'b0);
        wrc(12'h028, 32'h0000_0003, 1'b0);
        rdc("status", 12'h010, 32'h0000_0101, 1'b0);
        for (int i = 0; i < 4; i++) begin
            b = 8'h10 + 8'(4 * i);
            rdc("data", 12'h020, {b + 8'h3, b + 8'h2, b + 8'h1, b},
                1'b0);
        end
        rdc("status", 12'h010, 32'h0000_0000, 1'b0);
        // Interrupt masked, enabled, cleared
        wrc(12'h02c, 32'h0000_0000, 1'b0);
        rx_push(8'h55, 1);
        repeat (3) @(posedge sys_clk);
        check("irq_masked", {31'h0, irq}, 32'h0000_0000);
        rdc("int_status", 12'h024, 32'h0000_0001, 1'b0);
        wrc(12'h02c, 32'h0000_0003, 1'b0);
        repeat (2) @(posedge sys_clk);
        check("irq_enabled", {31'h0, irq}, 32'h0000_0001);
        rdc("int_enable", 12'h02c, 32'h0000_0003, 1'b0);
        wrc(12'h028, 32'h0000_0001, 1'b0);
        repeat (2) @(posedge sys_clk);
        check("irq_cleared", {31'h0, irq}, 32'h0000_0000);
        rdc("data", 12'h020, 32'h0000_0055, 1'b0);
        // Bytes arriving while status is cleared keep their bit
        rx_valid <= 1'b1;
        rx_data <= 8'h66;
        wrc(12'h028, 32'h0000_0001, 1'b0);
        rx_valid <= 1'b0;
        rdc("int_set_wins", 12'h024, 32'h0000_0001, 1'b0);
        rdc("status", 12'h010, 32'h0000_0030, 1'b0);
        // Unmapped address refused
        rdc("unmapped", 12'h3f0, 32'h0000_0000, 1'b1);
        wrc(12'h3f0, 32'h1234_5678, 1'b1);
        // Second reset in mid-run
        rx_push(8'h77, 2);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        check("irq_reset", {31'h0, irq}, 32'h0000_0000);
        rdc("status", 12'h010, 32'h0000_0000, 1'b0);
        rdc("int_enable", 12'h02c, 32'h0000_0000, 1'b0);
        rdc("rx_feature", 12'h00c, rx_feat, 1'b0);
        test_done();
    end

endmodule
